//--- rtl/csi_pkg.sv
// Constants and types shared by the clocked serial interface.
// Assumes a single-clock system at 25 MHz with a plain register port.
package csi_pkg;

	// Register offsets on the plain register port.
	localparam logic [31:0] CSI_MODE_OFF     = 32'hfffff900;
	localparam logic [31:0] CSI_CLKSEL_OFF   = 32'hfffff904;
	localparam logic [31:0] CSI_SHIFT_OFF    = 32'hfffff908;
	localparam logic [31:0] CSI_SHIFTL_OFF   = 32'hfffff90c;
	localparam logic [31:0] CSI_RXBUF_OFF    = 32'hfffff920;
	localparam logic [31:0] CSI_RXBUFL_OFF   = 32'hfffff924;
	localparam logic [31:0] CSI_RXMIR_OFF    = 32'hfffff928;
	localparam logic [31:0] CSI_RXMIRL_OFF   = 32'hfffff92c;
	localparam logic [31:0] CSI_TXBUF_OFF    = 32'hfffff930;
	localparam logic [31:0] CSI_TXBUFL_OFF   = 32'hfffff934;
	localparam logic [31:0] CSI_TXFIRST_OFF  = 32'hfffff938;
	localparam logic [31:0] CSI_TXFIRSTL_OFF = 32'hfffff93c;

	// Mode register fields and reset value.
	localparam int          CSI_EN_BIT    = 7;
	localparam int          CSI_TRMD_BIT  = 6;
	localparam int          CSI_LEN_BIT   = 5;
	localparam int          CSI_DIR_BIT   = 4;
	localparam int          CSI_ITIM_BIT  = 3;
	localparam int          CSI_AUTO_BIT  = 2;
	localparam int          CSI_BUSY_BIT  = 0;
	localparam logic [7:0]  CSI_MODE_RST  = 8'h00;
	localparam logic [7:0]  CSI_MODE_WMSK = 8'hfc;
	localparam logic [2:0]  CSI_CLKSEL_RST = 3'h0;
	localparam logic [2:0]  CSI_CLK_EXT   = 3'h7;
	localparam logic [15:0] CSI_BUF_RST   = 16'h0000;

	// Serial timing: 4 Mbps ceiling, 25 MHz system clock.
	localparam int          CSI_SYS_MHZ    = 25;
	localparam int          CSI_MAX_KBPS   = 4000;
	localparam int          CSI_MIN_HALF   = (CSI_SYS_MHZ * 1000 + 2 * CSI_MAX_KBPS - 1)
		/ (2 * CSI_MAX_KBPS);
	localparam logic [7:0]  CSI_HALF_BASE  = 8'(CSI_MIN_HALF);

	// Transfer sequencer states.
	typedef enum logic [2:0] {
		CSI_IDLE  = 3'b001,
		CSI_LOW   = 3'b010,
		CSI_HIGH  = 3'b100
	} csi_state_t;

endpackage : csi_pkg

//--- rtl/csi_clk_if.sv
// Interface between the transfer core and the serial clock generator.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
interface csi_clk_if;
	logic       run;
	logic [2:0] sel;
	logic       tick;

	modport core (output run, output sel, input tick);
	modport gen  (input run, input sel, output tick);
endinterface : csi_clk_if

//--- rtl/csi_clk_gen.sv
// Internal serial clock generator: half-period ticks for seven master rates.
// Assumes a system clock of 25 MHz and a clock enable from the core's owner.
`timescale 1ns/10ps
module csi_clk_gen
	import csi_pkg::*;
(
	input  wire logic i_mclk,
	input  wire logic i_reset_n,
	input  wire logic i_ce,
	csi_clk_if.gen    clk_bus
);
	logic [7:0] count_reg;
	logic [7:0] limit;

	// Half period doubles per selection step, never below the 4 Mbps floor.
	always_comb begin
		limit = 8'(CSI_HALF_BASE << clk_bus.sel);
	end

	// Counts system clocks while a transfer runs and ticks every half period.
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count_reg <= 8'h00;
		end else if (i_ce) begin
			if (!clk_bus.run || clk_bus.tick) begin
				count_reg <= 8'h00;
			end else begin
				count_reg <= count_reg + 8'h01;
			end
		end
	end

	assign clk_bus.tick = clk_bus.run && (count_reg == limit - 8'h01);
endmodule : csi_clk_gen

//--- rtl/csi_core.sv
// Clocked serial interface: three-wire master or slave transfer, full duplex in transmit mode.
// Assumes a plain register port on i_mclk and an external partner on the pins.
`timescale 1ns/10ps
module csi_core
	import csi_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	input  wire logic        i_ce,
	input  wire logic [31:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	input  wire logic        i_ser_data_in,
	output logic             o_ser_data_out,
	input  wire logic        i_ser_clock_pin,
	output logic             o_ser_clock_pin,
	output logic             o_ser_clock_pin_oe,
	output logic             o_xfer_done_irq
);
	import csi_pkg::*;

	csi_clk_if  clk_bus ();
	csi_state_t state_reg;
	logic [7:0]  mode_reg;
	logic [2:0]  clksel_reg;
	logic [15:0] shift_reg;
	logic [15:0] rx_reg;
	logic [15:0] tx_reg;
	logic [15:0] txfirst_reg;
	logic [4:0]  bitcnt_reg;
	logic        first_done_reg;
	logic        sck_out_reg;
	logic        sdo_reg;
	logic        irq_reg;
	logic [1:0]  sck_sync_reg;
	logic [1:0]  sdi_sync_reg;
	logic        sck_prev_reg;
	logic        enable;
	logic        tx_mode;
	logic        long_word;
	logic        lsb_first;
	logic        irq_late;
	logic        repeat_mode;
	logic        ext_clk;
	logic        busy;
	logic        wr_tx;
	logic        rd_rx;
	logic        start;
	logic        fall_evt;
	logic        rise_evt;
	logic        last_bit;
	logic        done;
	logic [4:0]  word_bits;
	logic [15:0] rx_word;
	logic [15:0] load_word;
	logic [15:0] tx_word;

	// Decoded control fields of the mode register.
	assign enable      = mode_reg[CSI_EN_BIT];
	assign tx_mode     = mode_reg[CSI_TRMD_BIT];
	assign long_word   = mode_reg[CSI_LEN_BIT];
	assign lsb_first   = mode_reg[CSI_DIR_BIT];
	assign irq_late    = mode_reg[CSI_ITIM_BIT];
	assign repeat_mode = mode_reg[CSI_AUTO_BIT];
	assign ext_clk     = (clksel_reg == CSI_CLK_EXT);
	assign busy        = (state_reg != CSI_IDLE);
	assign word_bits   = long_word ? 5'd16 : 5'd8;

	// Clock generator for the seven internal master rates.
	// rate floor applied
	csi_clk_gen u_clk_gen (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.clk_bus   (clk_bus.gen)
	);
	assign clk_bus.run = busy && !ext_clk;
	assign clk_bus.sel = clksel_reg;

	// Pin inputs pass two flip-flops before use.
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sck_sync_reg <= 2'b11;
			sdi_sync_reg <= 2'b00;
			sck_prev_reg <= 1'b1;
		end else if (i_ce) begin
			sck_sync_reg <= {sck_sync_reg[0], i_ser_clock_pin};
			sdi_sync_reg <= {sdi_sync_reg[0], i_ser_data_in};
			sck_prev_reg <= sck_sync_reg[1];
		end
	end

	always_comb begin
		if (ext_clk) begin
			fall_evt = busy && sck_prev_reg && !sck_sync_reg[1];
			rise_evt = busy && !sck_prev_reg && sck_sync_reg[1];
		end else begin
			fall_evt = clk_bus.tick && (state_reg == CSI_HIGH);
			rise_evt = clk_bus.tick && (state_reg == CSI_LOW);
		end
	end

	// Register access decode.
	// buffer access starts
	assign wr_tx = i_wr && (i_addr == CSI_TXBUF_OFF || i_addr == CSI_TXBUFL_OFF);
	assign rd_rx = i_rd && (i_addr == CSI_RXBUF_OFF || i_addr == CSI_RXBUFL_OFF);
	assign start = enable && !busy && (tx_mode ? wr_tx : rd_rx);

	assign last_bit = (bitcnt_reg == word_bits - 5'd1);
	assign done     = rise_evt && last_bit;

	// Received word with the final bit merged in.
	// receive bit order
	always_comb begin
		if (lsb_first) begin
			rx_word = long_word ? {sdi_sync_reg[1], shift_reg[15:1]}
				: {8'h00, sdi_sync_reg[1], shift_reg[7:1]};
		end else begin
			rx_word = {shift_reg[14:0], sdi_sync_reg[1]};
			if (!long_word) begin
				rx_word[15:8] = 8'h00;
			end
		end
	end

	// initial buffer first
	// The word being written is sent, since the buffer only updates at the same edge.
	assign tx_word   = (i_addr == CSI_TXBUF_OFF) ? i_wdata : {tx_reg[15:8], i_wdata[7:0]};
	assign load_word = (repeat_mode && !first_done_reg) ? txfirst_reg : tx_word;

	// Mode and clock-select registers; bit 1 and bit 0 are not writable.
	// busy bit read-only
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mode_reg   <= CSI_MODE_RST;
			clksel_reg <= CSI_CLKSEL_RST;
		end else if (i_ce && i_wr) begin
			if (i_addr == CSI_MODE_OFF) begin
				mode_reg <= i_wdata[7:0] & CSI_MODE_WMSK;
			end
			if (i_addr == CSI_CLKSEL_OFF) begin
				clksel_reg <= i_wdata[2:0];
			end
		end
	end

	// Transmit and initial transmit buffers; low views write the low byte.
	// transmit buffer views
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_reg      <= CSI_BUF_RST;
			txfirst_reg <= CSI_BUF_RST;
		end else if (i_ce && i_wr) begin
			unique case (i_addr)
				CSI_TXBUF_OFF:    tx_reg <= i_wdata;
				CSI_TXBUFL_OFF:   tx_reg <= {tx_reg[15:8], i_wdata[7:0]};
				CSI_TXFIRST_OFF:  txfirst_reg <= i_wdata;
				CSI_TXFIRSTL_OFF: txfirst_reg <= {txfirst_reg[15:8], i_wdata[7:0]};
				default: ;
			endcase
		end
	end

	// Transfer sequencer, shift register and bit counter.
	// disable returns idle
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg      <= CSI_IDLE;
			shift_reg      <= CSI_BUF_RST;
			bitcnt_reg     <= 5'd0;
			first_done_reg <= 1'b0;
		end else if (i_ce) begin
			if (!enable) begin
				state_reg      <= CSI_IDLE;
				bitcnt_reg     <= 5'd0;
				first_done_reg <= 1'b0;
			end else if (start) begin
				state_reg  <= CSI_HIGH;
				shift_reg  <= tx_mode ? load_word : CSI_BUF_RST;
				bitcnt_reg <= 5'd0;
				if (tx_mode) begin
					first_done_reg <= 1'b1;
				end
			end else if (fall_evt) begin
				state_reg <= CSI_LOW;
			end else if (rise_evt) begin
				if (lsb_first) begin
					shift_reg <= long_word ? {sdi_sync_reg[1], shift_reg[15:1]}
						: {8'h00, sdi_sync_reg[1], shift_reg[7:1]};
				end else begin
					shift_reg <= {shift_reg[14:0], sdi_sync_reg[1]};
				end
				bitcnt_reg <= last_bit ? 5'd0 : bitcnt_reg + 5'd1;
				state_reg  <= last_bit ? CSI_IDLE : CSI_HIGH;
			end
		end
	end

	// Serial data out changes on the falling clock edge.
	// MSB or LSB first
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sdo_reg <= 1'b0;
		end else if (i_ce) begin
			if (!enable || !tx_mode) begin
				sdo_reg <= 1'b0;
			end else if (fall_evt) begin
				sdo_reg <= lsb_first ? shift_reg[0]
					: (long_word ? shift_reg[15] : shift_reg[7]);
			end
		end
	end

	// Master clock output follows the sequencer phase.
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sck_out_reg <= 1'b1;
		end else if (i_ce) begin
			if (fall_evt) begin
				sck_out_reg <= 1'b0;
			end else if (rise_evt || state_reg != CSI_LOW) begin
				sck_out_reg <= 1'b1;
			end
		end
	end

	assign o_ser_clock_pin    = sck_out_reg;
	assign o_ser_clock_pin_oe = enable && !ext_clk;
	assign o_ser_data_out     = sdo_reg;

	// Receive buffer and completion interrupt pulse.
	// completion updates
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_reg  <= CSI_BUF_RST;
			irq_reg <= 1'b0;
		end else if (i_ce) begin
			irq_reg <= 1'b0;
			if (enable && done) begin
				rx_reg  <= rx_word;
				irq_reg <= 1'b1;
			end
		end
	end
	// Late timing adds one cycle of delay to the request.
	logic irq_dly_reg;
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_dly_reg <= 1'b0;
		end else if (i_ce) begin
			irq_dly_reg <= irq_reg;
		end
	end
	assign o_xfer_done_irq = irq_late ? irq_dly_reg : irq_reg;

	// Read data one cycle after the read strobe; unmapped reads return zero.
	// mirror returns receive
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 16'h0000;
		end else if (i_ce) begin
			o_rdata <= 16'h0000;
			if (i_rd) begin
				unique case (i_addr)
					CSI_MODE_OFF:     o_rdata <= {8'h00, mode_reg[7:1], busy};
					CSI_CLKSEL_OFF:   o_rdata <= {13'h0000, clksel_reg};
					CSI_SHIFT_OFF:    o_rdata <= shift_reg;
					CSI_SHIFTL_OFF:   o_rdata <= {8'h00, shift_reg[7:0]};
					CSI_RXBUF_OFF,
					CSI_RXMIR_OFF:    o_rdata <= rx_reg;
					CSI_RXBUFL_OFF,
					CSI_RXMIRL_OFF:   o_rdata <= {8'h00, rx_reg[7:0]};
					CSI_TXBUF_OFF:    o_rdata <= tx_reg;
					CSI_TXBUFL_OFF:   o_rdata <= {8'h00, tx_reg[7:0]};
					CSI_TXFIRST_OFF:  o_rdata <= txfirst_reg;
					CSI_TXFIRSTL_OFF: o_rdata <= {8'h00, txfirst_reg[7:0]};
					default:          o_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// Assertions.
	sequence xfer_start_s;
		i_ce && start && tx_mode;
	endsequence
	sequence busy_bit_s;
		busy ##1 busy;
	endsequence

	start_sets_busy_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		xfer_start_s |=> busy)
		else $error("transmit start did not set busy");
	disable_idles_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_ce && !enable |=> !busy && bitcnt_reg == 5'd0)
		else $error("disable did not return to idle");
	done_pulse_irq_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_ce && enable && done && !irq_late |=> o_xfer_done_irq && !busy)
		else $error("completion did not pulse interrupt");
	irq_one_cycle_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_ce && irq_reg |=> !irq_reg || !i_ce)
		else $error("interrupt longer than one cycle");
	pin_oe_master_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		ext_clk |-> !o_ser_clock_pin_oe)
		else $error("clock pin driven in slave mode");
	busy_readback_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_ce && i_rd && i_addr == CSI_MODE_OFF |=> o_rdata[0] == $past(busy) && !o_rdata[1])
		else $error("busy bit readback wrong");
	mirror_equal_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_ce && i_rd && i_addr == CSI_RXMIR_OFF && !(enable && done) |=> o_rdata == rx_reg)
		else $error("mirror differs from receive buffer");
	count_bound_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		bitcnt_reg < word_bits || !busy)
		else $error("bit counter past word length");
	shift_no_start_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		i_ce && !busy && i_wr && i_addr == CSI_SHIFT_OFF |=> !busy)
		else $error("shift register access started a transfer");
	busy_held_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		busy_bit_s |-> long_word || bitcnt_reg <= 5'd7)
		else $error("eight-bit word counted past seven");
endmodule : csi_core

//--- tb/csi_peer.sv
// Far-side serial device: slave on the block's clock, or clock source.
// Assumes the bench resolves the clock wire and pulses i_clr per word.
`timescale 1ns/10ps
module csi_peer (
	input  wire logic        i_sck,
	input  wire logic        i_sdo,
	input  wire logic        i_go,
	input  wire logic        i_clr,
	input  wire logic        i_len16,
	input  wire logic        i_lsb,
	input  wire logic [15:0] i_word,
	output logic             o_sdi,
	output logic             o_sck,
	output logic             o_sck_oe,
	output logic [15:0]      o_rx
);
	int n_out;
	int n_in;

	function automatic int pos(input int k);
		return i_lsb ? k : (i_len16 ? 15 : 7) - k;
	endfunction : pos

	// falling edge out
	// The next bit is put out on each falling clock edge.
	always @(negedge i_sck or posedge i_clr) begin
		if (i_clr) begin
			n_out = 0;
			o_sdi = 1'b1;
		end else if (n_out < (i_len16 ? 16 : 8)) begin
			o_sdi = i_word[pos(n_out)];
			n_out++;
		end
	end

	// rising edge in
	// Bits are taken on rising edges; the line flips a little after the last one.
	always @(posedge i_sck or posedge i_clr) begin
		if (i_clr) begin
			n_in = 0;
			o_rx = 16'h0000;
		end else if (n_in < n_out) begin
			o_rx[pos(n_in)] = i_sdo;
			n_in++;
			if (n_in == (i_len16 ? 16 : 8))
				o_sdi <= #130 ~o_sdi;
		end
	end

	// external clock source
	// The clock runs only inside a frame and rests high between frames.
	initial begin
		o_sck = 1'b1;
		o_sck_oe = 1'b0;
		forever begin
			@(posedge i_go);
			#7 o_sck_oe = 1'b1;
			repeat (i_len16 ? 16 : 8) begin
				#160 o_sck = 1'b0;
				#160 o_sck = 1'b1;
			end
			#160 o_sck_oe = 1'b0;
		end
	end
endmodule : csi_peer

//--- tb/testbench.sv
// Self-checking bench for the clocked serial interface and a far-side model.
// Assumes a pull-up on the clock wire and a 25 MHz system clock.
`timescale 1ns/10ps
module testbench;
	import csi_pkg::*;
	logic        clk;
	logic        rst_n;
	logic        ce;
	logic [31:0] addr;
	logic [15:0] wdata;
	logic        wr_s;
	logic        rd_s;
	logic        rd_d;
	logic [15:0] rdata;
	logic        sdi;
	logic        sdo;
	logic        sck_o;
	logic        sck_oe;
	logic        irq;
	logic        p_sck;
	logic        p_oe;
	logic        p_go;
	logic        p_clr;
	logic        p_len16;
	logic        p_lsb;
	logic [15:0] p_word;
	logic [15:0] p_rx;
	logic [15:0] rd_q[$];
	logic [15:0] ser_q[$];
	logic [31:0] seed;
	logic [15:0] last_rx;
	int          n_fail;
	int          compares;
	int          n_irq;
	int          lo_cnt;
	int          lo_last;
	// The clock wire is pulled high when nobody drives it.
	wire         sck_w = sck_oe ? sck_o : (p_oe ? p_sck : 1'b1);

	csi_core u_dut (
		.i_mclk             (clk),
		.i_reset_n          (rst_n),
		.i_ce               (ce),
		.i_addr             (addr),
		.i_wdata            (wdata),
		.i_wr               (wr_s),
		.i_rd               (rd_s),
		.o_rdata            (rdata),
		.i_ser_data_in      (sdi),
		.o_ser_data_out     (sdo),
		.i_ser_clock_pin    (sck_w),
		.o_ser_clock_pin    (sck_o),
		.o_ser_clock_pin_oe (sck_oe),
		.o_xfer_done_irq    (irq)
	);

	csi_peer u_peer (
		.i_sck    (sck_w),
		.i_sdo    (sdo),
		.i_go     (p_go),
		.i_clr    (p_clr),
		.i_len16  (p_len16),
		.i_lsb    (p_lsb),
		.i_word   (p_word),
		.o_sdi    (sdi),
		.o_sck    (p_sck),
		.o_sck_oe (p_oe),
		.o_rx     (p_rx)
	);

	// System clock of 40 ns.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction : rnd

	task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_word

	task automatic cmp_bit(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp_bit

	task automatic close_out();
		$display("counts compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [15:0] e);
		rd_q.push_back(e);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(posedge clk);
	endtask : rd

	task automatic wait_irq();
		int k;
		for (k = 0; k < 3000; k++) begin
			@(posedge clk);
			if (irq === 1'b1)
				break;
		end
		if (k == 3000) begin
			n_fail++;
			$display("BAD irq expected 1 seen 0");
			close_out();
		end
	endtask : wait_irq

	// One word each way; the expected serial word is queued before the start, the expected receive readback after the interrupt.
	task automatic xfer(input logic [7:0] m, input logic [15:0] tw, input logic [15:0] pw,
			input logic [15:0] fw, input logic [2:0] sel, input logic renew);
		logic [15:0] msk;
		logic [31:0] ra;
		logic [31:0] rb;
		msk = m[CSI_LEN_BIT] ? 16'hffff : 16'h00ff;
		ra = m[CSI_LEN_BIT] ? (m[CSI_DIR_BIT] ? CSI_RXMIR_OFF : CSI_RXBUF_OFF)
			: (m[CSI_DIR_BIT] ? CSI_RXMIRL_OFF : CSI_RXBUFL_OFF);
		rb = m[CSI_TRMD_BIT] ? ra : (m[CSI_LEN_BIT] ? CSI_RXMIR_OFF : CSI_RXMIRL_OFF);
		p_len16 <= m[CSI_LEN_BIT];
		p_lsb <= m[CSI_DIR_BIT];
		p_word <= pw;
		p_clr <= 1'b1;
		wr(CSI_CLKSEL_OFF, {13'h0000, sel});
		p_clr <= 1'b0;
		if (renew) begin
			wr(CSI_MODE_OFF, 16'h0000);
			wr(CSI_MODE_OFF, {8'h00, m});
			wr(CSI_TXFIRST_OFF, fw);
		end
		if (m[CSI_TRMD_BIT]) begin
			ser_q.push_back((m[CSI_AUTO_BIT] && renew ? fw : tw) & msk);
			wr(m[CSI_LEN_BIT] ? CSI_TXBUF_OFF : CSI_TXBUFL_OFF, tw);
		end else begin
			ser_q.push_back(16'h0000);
			rd(ra, last_rx);
		end
		cmp_bit("oe", sel != CSI_CLK_EXT, sck_oe);
		rd(CSI_MODE_OFF, {8'h00, m | 8'h01});
		if (m[CSI_TRMD_BIT])
			wr(CSI_TXBUFL_OFF, ~tw);
		if (sel == CSI_CLK_EXT)
			p_go <= 1'b1;
		wait_irq();
		p_go <= 1'b0;
		rd(rb, pw & msk);
		last_rx = pw & msk;
		rd(CSI_MODE_OFF, {8'h00, m});
		if (sel != CSI_CLK_EXT)
			cmp_word("half", 16'(4 << sel), 16'(lo_last));
	endtask : xfer

	// Length of the last low phase of the driven clock.
	always @(posedge clk) begin
		if (sck_oe === 1'b1 && sck_o === 1'b0)
			lo_cnt <= lo_cnt + 1;
		else if (lo_cnt != 0) begin
			lo_last <= lo_cnt;
			lo_cnt <= 0;
		end
	end

	// Watcher: read data the cycle after a read, peer word at each pulse.
	always @(posedge clk) begin
		rd_d <= rd_s;
		if (rd_d === 1'b1)
			cmp_word("rdata", rd_q.pop_front(), rdata);
		if (irq === 1'b1) begin
			n_irq++;
			if (ser_q.size() > 0)
				cmp_word("serial", ser_q.pop_front(), p_rx);
			else begin
				n_fail++;
				$display("BAD irq expected 0 seen 1");
			end
		end
	end

	initial begin
		int i;
		int k;
		logic [7:0] m;
		seed = 32'h00005b4f;
		rst_n = 1'b0;
		ce = 1'b1;
		addr = 32'h00000000;
		wdata = 16'h0000;
		wr_s = 1'b0;
		rd_s = 1'b0;
		rd_d = 1'b0;
		p_go = 1'b0;
		p_clr = 1'b1;
		p_len16 = 1'b0;
		p_lsb = 1'b0;
		p_word = 16'h0000;
		last_rx = 16'h0000;
		n_fail = 0;
		compares = 0;
		n_irq = 0;
		lo_cnt = 0;
		lo_last = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		p_clr <= 1'b0;
		rd(CSI_MODE_OFF, 16'h0000);
		rd(CSI_CLKSEL_OFF, 16'h0000);
		rd(CSI_RXBUF_OFF, CSI_BUF_RST);
		rd(32'hfffff9f0, 16'h0000);
		cmp_bit("oe", 1'b0, sck_oe);
		wr(CSI_MODE_OFF, 16'h0013);
		rd(CSI_MODE_OFF, 16'h0010);
		$display("done reset and mode");
		for (i = 0; i < 4; i++) begin
			m = 8'hc0 | {2'h0, i[1], i[0], i == 3, 3'h0};
			xfer(m, rnd(), rnd(), 16'h0000, i == 2 ? 3'h1 : 3'h0, 1'b1);
		end
		$display("done formats");
		wr(CSI_SHIFT_OFF, rnd());
		rd(CSI_MODE_OFF, 16'h00f8);
		xfer(8'ha0, 16'h0000, rnd(), 16'h0000, 3'h0, 1'b1);
		$display("done receive only");
		xfer(8'hf0, rnd(), rnd(), 16'h0000, CSI_CLK_EXT, 1'b1);
		$display("done slave");
		xfer(8'hc4, rnd(), rnd(), rnd(), 3'h0, 1'b1);
		xfer(8'hc4, rnd(), rnd(), 16'h0000, 3'h0, 1'b0);
		$display("done repeat");
		wr(CSI_MODE_OFF, 16'h00c0);
		wr(CSI_TXBUFL_OFF, rnd());
		repeat (20) @(posedge clk);
		k = n_irq;
		ce <= 1'b0;
		repeat (100) @(posedge clk);
		cmp_bit("frozen", 1'b1, n_irq == k);
		ce <= 1'b1;
		wr(CSI_MODE_OFF, 16'h0000);
		rd(CSI_MODE_OFF, 16'h0000);
		cmp_bit("oe", 1'b0, sck_oe);
		repeat (200) @(posedge clk);
		cmp_word("irqs", 16'(k), 16'(n_irq));
		xfer(8'hc0, rnd(), rnd(), 16'h0000, 3'h0, 1'b1);
		$display("done abort");
		close_out();
	end
endmodule : testbench
